//--- bench/tpg_entry_model.sv
// Far-side model: one translation entry matched against the lookup address
`timescale 1ns/100ps
module tpg_entry_model
   import tpg_pkg::*;
(
   input  wire logic [31:0]       i_va,
   input  wire logic [20:0]       i_vpn,
   input  wire logic [SPAN_W-1:0] i_mask,
   output logic                   o_hit
);
   // Address bits under a set mask bit take no part in the match
   assign o_hit = ((i_va[31:11] ^ i_vpn) & ~{7'h00, i_mask}) == 21'h000000;
endmodule // tpg_entry_model

//--- bench/tpg_page_grain_chk.sv
// Concurrent checks on the page granularity logic ports
`timescale 1ns/100ps
module tpg_page_grain_chk
   import tpg_pkg::*;
(
   input wire logic                       i_clk,
   input wire logic                       i_rst,
   input wire logic                       i_ce,
   input wire logic                       i_lk_valid,
   input wire logic                       i_lk_mapped,
   input wire logic                       i_lk_hit,
   input wire tpg_ref_type                i_lk_ref,
   input wire logic [31:0]                i_lk_va,
   input wire logic [TAG_W-1:0]           i_lk_space_tag,
   input wire logic                       i_exception_level_flag,
   input wire logic [SPAN_W-1:0]          i_ent_mask,
   input wire logic [1:0]                 i_ent_present,
   input wire logic [1:0]                 i_ent_write_permit,
   input wire logic                       o_xlat_valid,
   input wire logic [PHYS_ADDR_WIDTH-1:0] o_pa,
   input wire logic                       o_exc_refill,
   input wire logic                       o_exc_nested_miss,
   input wire logic                       o_exc_invalid,
   input wire logic                       o_exc_modified,
   input wire logic [SPAN_W-1:0]          o_eff_mask,
   input wire logic [GRAIN_W-1:0]         o_grain_mask,
   input wire logic [31:0]                o_match_high
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // Exceptions whose capture is checked; the nested miss also captures but is left out
   wire logic cap_exc = o_exc_refill | o_exc_invalid | o_exc_modified;
   // Mapped lookup taken, and its miss case
   sequence s_req;
      i_ce && i_lk_valid && i_lk_mapped;
   endsequence
   sequence s_miss;
      s_req ##0 !i_lk_hit;
   endsequence
   a_refill_on_miss: assert property (s_miss ##0 !i_exception_level_flag |=> o_exc_refill)
      else $error("refill not raised on miss");
   a_nested_miss: assert property (s_miss ##0 i_exception_level_flag |=>
      o_exc_nested_miss && !o_exc_refill) else $error("nested miss not flagged alone");
   a_invalid_absent: assert property (s_req ##0 i_lk_hit && i_ent_present == 2'h0
      |=> o_exc_invalid) else $error("invalid not raised");
   a_modified_store: assert property (s_req ##0 i_lk_hit && i_ent_present == 2'h3
      && i_lk_ref == tpg_ref_store && i_ent_write_permit == 2'h0 |=> o_exc_modified)
      else $error("modified not raised");
   a_unmapped_quiet: assert property (i_ce && i_lk_valid && !i_lk_mapped
      |=> !o_xlat_valid && !cap_exc) else $error("unmapped lookup produced an event");
   a_single_event: assert property ($onehot0({o_xlat_valid, o_exc_refill,
      o_exc_nested_miss, o_exc_invalid, o_exc_modified})) else $error("several events at once");
   a_match_capture: assert property (i_ce && cap_exc |=>
      o_match_high[31:13] == $past(i_lk_va[31:13], 2)
      && o_match_high[12:11] == ($past(i_lk_va[12:11], 2) & ~o_grain_mask)
      && o_match_high[7:0] == $past(i_lk_space_tag, 2)) else $error("match-high capture wrong");
   a_offset_pass: assert property (o_xlat_valid |-> o_pa[9:0] == $past(i_lk_va[9:0]))
      else $error("page offset not passed");
   a_eff_mask_or: assert property (i_ce && i_lk_valid |=>
      o_eff_mask == ($past(i_ent_mask) | {12'h000, o_grain_mask})) else $error("effective mask wrong");
   a_grain_reset: assert property ($fell(i_rst) |-> o_grain_mask == 2'h3)
      else $error("grain mask reset value wrong");
endmodule // tpg_page_grain_chk

bind tpg_page_grain tpg_page_grain_chk tpg_page_grain_chk_inst (
   .i_clk, .i_rst, .i_ce, .i_lk_valid, .i_lk_mapped, .i_lk_hit, .i_lk_ref, .i_lk_va,
   .i_lk_space_tag, .i_exception_level_flag, .i_ent_mask, .i_ent_present, .i_ent_write_permit,
   .o_xlat_valid, .o_pa, .o_exc_refill, .o_exc_nested_miss, .o_exc_invalid, .o_exc_modified,
   .o_eff_mask, .o_grain_mask, .o_match_high);

//--- bench/tpg_page_grain_tb.sv
// Self-checking bench for the page granularity logic
`timescale 1ns/100ps
module tpg_page_grain_tb
   import tpg_pkg::*;
;
   logic i_clk = 1'b0, i_rst = 1'b1, i_ce = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
   logic i_lk_valid = 1'b0, i_lk_mapped = 1'b0, i_lk_pc_rel_load = 1'b0, i_lk_hit;
   logic i_exception_level_flag = 1'b0, o_xlat_valid, o_exc_refill, o_exc_nested_miss;
   logic o_exc_invalid, o_exc_modified, o_mask_undefined;
   logic [2:0] i_reg_sel = 3'h0;
   logic [31:0] i_reg_wdata = 32'h0, i_lk_va = 32'h0, o_reg_rdata, o_pa, o_match_high, fe;
   logic [31:0] o_frame_even, o_frame_odd;
   tpg_ref_type i_lk_ref = tpg_ref_load;
   logic [TAG_W-1:0] i_lk_space_tag = 8'h00;
   logic [SPAN_W-1:0] i_ent_mask = 14'h0, o_eff_mask, o_wr_mask, mk;
   logic [PFN_W-1:0] i_ent_pfn_even = 20'h0, i_ent_pfn_odd = 20'h0;
   logic [1:0] i_ent_present = 2'h0, i_ent_write_permit = 2'h0, i_ent_load_block = 2'h0;
   logic [1:0] i_ent_fetch_block = 2'h0, o_grain_mask, g;
   logic [20:0] ent_vpn = 21'h0;
   logic [SPAN_W-1:0] ml [9] = '{MASK_1K, MASK_2K, MASK_4K, MASK_16K, MASK_64K,
                                 MASK_256K, MASK_1M, MASK_4M, MASK_16M};
   logic [1:0] gl [3] = '{2'h3, 2'h0, 2'h1};
   // Exception cases: reference, mapped, hit, {present, write, load blk, fetch blk, pc-rel, level}
   logic [9:0] tbl [10] = '{10'h080, 10'h081, 10'h100, 10'h0C0, 10'h1E0,
                            10'h0E8, 10'h0EA, 10'h0EE, 10'h2E4, 10'h1F0};
   int n_mismatch = 0, n_compared = 0;
   integer seed = 32'h12AE3CF5;

   // Free-running clock
   always #4 i_clk = ~i_clk;

   tpg_page_grain tpg_page_grain_inst (
      .i_clk, .i_rst, .i_ce, .i_reg_wr, .i_reg_rd, .i_reg_sel, .i_reg_wdata, .i_lk_valid,
      .i_lk_mapped, .i_lk_hit, .i_lk_ref, .i_lk_pc_rel_load, .i_lk_va, .i_lk_space_tag,
      .i_exception_level_flag, .i_ent_mask, .i_ent_pfn_even, .i_ent_pfn_odd, .i_ent_present,
      .i_ent_write_permit, .i_ent_load_block, .i_ent_fetch_block, .o_reg_rdata, .o_xlat_valid,
      .o_pa, .o_exc_refill, .o_exc_nested_miss, .o_exc_invalid, .o_exc_modified, .o_eff_mask,
      .o_mask_undefined, .o_wr_mask, .o_grain_mask, .o_match_high, .o_frame_even, .o_frame_odd);

   tpg_entry_model tpg_entry_model_inst (.i_va(i_lk_va), .i_vpn(ent_vpn), .i_mask(i_ent_mask),
      .o_hit(i_lk_hit));

   // Counts and reports one comparison
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Prints the counts and the verdict, then stops
   task automatic complete_run;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // One-cycle register write
   task automatic wr(input logic [2:0] s, input logic [31:0] d);
      @(posedge i_clk);
      i_reg_wr <= 1'b1;
      i_reg_sel <= s;
      i_reg_wdata <= d;
      @(posedge i_clk);
      i_reg_wr <= 1'b0;
   endtask

   // Register read compared once the read data has landed
   task automatic rdc(input string nm, input logic [2:0] s, input logic [31:0] e);
      @(posedge i_clk);
      i_reg_rd <= 1'b1;
      i_reg_sel <= s;
      @(posedge i_clk);
      i_reg_rd <= 1'b0;
      @(negedge i_clk);
      chk(nm, o_reg_rdata, e);
   endtask

   // One lookup, with events and physical address predicted alongside
   task automatic lk(input tpg_ref_type r, input logic m, h, input logic [5:0] f,
                     input logic [31:0] va);
      logic [4:0] e;
      logic [7:0] tg;
      logic [13:0] ef;
      logic [19:0] pf;
      logic [21:0] pp;
      logic [31:0] pa;
      int eo;
      tg = 8'($random(seed));
      @(posedge i_clk);
      i_lk_valid <= 1'b1;
      i_lk_ref <= r;
      i_lk_mapped <= m;
      i_lk_va <= va;
      i_lk_space_tag <= tg;
      ent_vpn <= h ? va[31:11] : ~va[31:11];
      i_ent_mask <= mk;
      i_ent_pfn_even <= 20'($random(seed));
      i_ent_pfn_odd <= 20'($random(seed));
      i_ent_present <= {2{f[5]}};
      i_ent_write_permit <= {2{f[4]}};
      i_ent_load_block <= {2{f[3]}};
      i_ent_fetch_block <= {2{f[2]}};
      i_lk_pc_rel_load <= f[1];
      i_exception_level_flag <= f[0];
      @(posedge i_clk);
      i_lk_valid <= 1'b0;
      @(negedge i_clk);
      if (!m) e = 5'h00;
      else if (!h) e = f[0] ? 5'h04 : 5'h08;
      else if (!f[5] || (r == tpg_ref_load && f[3] && !(f[1] && !f[2]))
               || (r == tpg_ref_fetch && f[2])) e = 5'h02;
      else if (r == tpg_ref_store && !f[4]) e = 5'h01;
      else e = 5'h10;
      chk("events", {26'h0, o_mask_undefined, o_xlat_valid, o_exc_refill, o_exc_nested_miss,
          o_exc_invalid, o_exc_modified}, {27'h0, e});
      ef = mk | {12'h000, g};
      eo = 10;
      for (int b = 0; b < SPAN_W; b++) eo += ef[b];
      pf = va[eo] ? i_ent_pfn_odd : i_ent_pfn_even;
      pp = (g == 2'h0) ? {2'h0, pf} : (g == 2'h1) ? {1'b0, pf, 1'b0} : {pf, 2'h0};
      pa = ({pp, 10'h000} >> eo << eo) | (va & ((32'h1 << eo) - 32'h1));
      if (e[4]) chk("pa", o_pa, pa);
      if ((e & 5'h0B) != 5'h00) begin
         rdc("match high", SEL_MATCH_HIGH, {va[31:13], va[12:11] & ~g, 3'h0, tg});
         rdc("fault addr", SEL_FAULT_ADDR, va);
         chk("frame even", o_frame_even, fe);
         chk("frame odd", o_frame_odd, 32'h3FFFFFFF);
      end
   endtask

   // Hang guard
   initial begin
      repeat (20000) @(posedge i_clk);
      n_mismatch++;
      complete_run();
   end

   // Main sequence
   initial begin
      repeat (8) @(posedge i_clk);
      i_rst <= 1'b0;
      rdc("grain", SEL_GRAIN, 32'h00001F00);
      rdc("span", SEL_PAGE_SPAN, 32'h00000000);
      wr(SEL_FRAME_EVEN, 32'hFFFFFFFF);
      rdc("frame even", SEL_FRAME_EVEN, 32'h3FFFFFFF);
      wr(SEL_FRAME_ODD, 32'hFFFFFFFF);
      rdc("frame odd", SEL_FRAME_ODD, 32'h3FFFFFFF);
      chk("frame odd out", o_frame_odd, 32'h3FFFFFFF);
      rdc("unmapped", 3'h7, 32'h00000000);
      wr(SEL_GRAIN, 32'hC000E0FF);
      rdc("grain", SEL_GRAIN, 32'hC0000700);
      wr(SEL_FRAME_EVEN, 32'hFFFFFFFF);
      fe = 32'hFFFFFFFF;
      rdc("frame even", SEL_FRAME_EVEN, fe);
      foreach (gl[k]) begin
         g = gl[k];
         wr(SEL_GRAIN, {2'h3, 17'h00000, g, 11'h700});
         wr(SEL_PAGE_SPAN, {7'h00, MASK_16M, 11'h000});
         rdc("span", SEL_PAGE_SPAN, {7'h00, MASK_16M & ~{12'h000, g}, 11'h000});
         chk("wr mask", o_wr_mask, MASK_16M);
         rdc("grain", SEL_GRAIN, {2'h3, 17'h00000, g, 11'h700});
         for (int s = 0; s < 9; s++) begin
            mk = ml[s];
            lk(tpg_ref_type'(2'($unsigned($random(seed)) % 3)), 1'b1, 1'b1, 6'h30, $random(seed));
         end
      end
      mk = MASK_4K;
      foreach (tbl[t]) lk(tpg_ref_type'(tbl[t][9:8]), tbl[t][7], tbl[t][6], tbl[t][5:0],
                          $random(seed));
      // Clock enable low: a grain write must not land
      @(posedge i_clk);
      i_ce <= 1'b0;
      wr(SEL_GRAIN, 32'h00000700);
      i_ce <= 1'b1;
      rdc("frozen grain", SEL_GRAIN, {2'h3, 17'h00000, g, 11'h700});
      complete_run();
   end
endmodule // tpg_page_grain_tb

//--- core/tpg_page_grain.sv
// Page size, granularity control and TLB exception capture logic
`timescale 1ns/100ps
module tpg_page_grain
   import tpg_pkg::*;
(
   input  wire logic                 i_clk,
   input  wire logic                 i_rst,
   input  wire logic                 i_ce,
   input  wire logic                 i_reg_wr,
   input  wire logic                 i_reg_rd,
   input  wire logic [2:0]           i_reg_sel,
   input  wire logic [31:0]          i_reg_wdata,
   input  wire logic                 i_lk_valid,
   input  wire logic                 i_lk_mapped,
   input  wire logic                 i_lk_hit,
   input  wire tpg_ref_type          i_lk_ref,
   input  wire logic                 i_lk_pc_rel_load,
   input  wire logic [31:0]          i_lk_va,
   input  wire logic [TAG_W-1:0]     i_lk_space_tag,
   input  wire logic                 i_exception_level_flag,
   input  wire logic [SPAN_W-1:0]    i_ent_mask,
   input  wire logic [PFN_W-1:0]     i_ent_pfn_even,
   input  wire logic [PFN_W-1:0]     i_ent_pfn_odd,
   input  wire logic [1:0]           i_ent_present,
   input  wire logic [1:0]           i_ent_write_permit,
   input  wire logic [1:0]           i_ent_load_block,
   input  wire logic [1:0]           i_ent_fetch_block,
   output logic [31:0]               o_reg_rdata,
   output logic                      o_xlat_valid,
   output logic [PHYS_ADDR_WIDTH-1:0] o_pa,
   output logic                      o_exc_refill,
   output logic                      o_exc_nested_miss,
   output logic                      o_exc_invalid,
   output logic                      o_exc_modified,
   output logic [SPAN_W-1:0]         o_eff_mask,
   output logic                      o_mask_undefined,
   output logic [SPAN_W-1:0]         o_wr_mask,
   output logic [GRAIN_W-1:0]        o_grain_mask,
   output logic [31:0]               o_match_high,
   output logic [31:0]               o_frame_even,
   output logic [31:0]               o_frame_odd
);

   // Software visible state
   logic [SPAN_W-1:0]   span;
   logic [GRAIN_W-1:0]  grain;
   logic                load_block_enable;
   logic                fetch_block_enable;
   logic [31:0]         tlb_match_high;
   logic [31:0]         tlb_frame_even;
   logic [31:0]         tlb_frame_odd;
   logic [31:0]         faulting_address_reg;

   // Effective mask and even/odd select of the matching entry
   logic [SPAN_W-1:0]   next_eff_mask;
   logic [EO_W-1:0]     next_eo_bit;
   logic                next_undef;
   logic                sel_odd;

   // Flags and frame number of the selected half
   logic                cur_present;
   logic                cur_permit;
   logic                cur_lblk;
   logic                cur_fblk;
   logic [PFN_W-1:0]    cur_pfn;

   // Physical address assembly
   logic [PA_PFN_W-1:0] pa_pfn;
   logic [31:0]         low_bits;
   logic [PHYS_ADDR_WIDTH-1:0] next_pa;

   // Exception decision
   logic                lookup;
   logic                next_refill;
   logic                next_nested;
   logic                next_invalid;
   logic                next_modified;
   logic                any_exc;

   // Read data and grain mask widened to the size select field
   logic [31:0]         next_rdata;
   logic [SPAN_W-1:0]   grain_wide;

   // Size select field to even/odd select bit
   function automatic logic [EO_W:0] eo_decode(input logic [SPAN_W-1:0] m);
      logic [EO_W:0] r;
      r = {1'b0, EO_4K};
      unique case (m)
         MASK_1K:   r = {1'b0, EO_1K};
         MASK_2K:   r = {1'b0, EO_2K};
         MASK_4K:   r = {1'b0, EO_4K};
         MASK_16K:  r = {1'b0, EO_16K};
         MASK_64K:  r = {1'b0, EO_64K};
         MASK_256K: r = {1'b0, EO_256K};
         MASK_1M:   r = {1'b0, EO_1M};
         MASK_4M:   r = {1'b0, EO_4M};
         MASK_16M:  r = {1'b0, EO_16M};
         // Top bit flags an encoding outside the list
         default:   r = {1'b1, EO_4K};
      endcase
      return r;
   endfunction

   // Grain mask widened to the size select field
   function automatic logic [SPAN_W-1:0] widen(input logic [GRAIN_W-1:0] g);
      return {{(SPAN_W-GRAIN_W){1'b0}}, g};
   endfunction

   // Write strobe decode for one register select
   function automatic logic reg_write(input logic wr, input logic [2:0] sel,
                                      input logic [2:0] which);
      return wr && (sel == which);
   endfunction

   assign grain_wide = widen(grain);

   // Offset bits below the even/odd bit pass through
   genvar gi;
   generate
      for (gi = 0; gi < 32; gi++) begin : g_low
         assign low_bits[gi] = (gi < int'(next_eo_bit)); // RULE1
      end
   endgenerate

   // Effective mask, frame select and exception decision in the lookup cycle
   always_comb begin
      next_eff_mask = i_ent_mask | grain_wide; // RULE23 RULE8
      {next_undef, next_eo_bit} = eo_decode(next_eff_mask); // RULE10
      // Pick the even or odd half by the select bit
      sel_odd     = i_lk_va[next_eo_bit]; // RULE1
      cur_present = sel_odd ? i_ent_present[1] : i_ent_present[0];
      cur_permit  = sel_odd ? i_ent_write_permit[1] : i_ent_write_permit[0];
      cur_lblk    = (sel_odd ? i_ent_load_block[1] : i_ent_load_block[0]) & load_block_enable;
      cur_fblk    = (sel_odd ? i_ent_fetch_block[1] : i_ent_fetch_block[0]) & fetch_block_enable;
      cur_pfn     = sel_odd ? i_ent_pfn_odd : i_ent_pfn_even;
      // Frame number aligned to the grain
      unique case (grain)
         2'h0:    pa_pfn = {2'h0, cur_pfn}; // RULE18
         2'h1:    pa_pfn = {1'b0, cur_pfn, 1'b0}; // RULE19
         default: pa_pfn = {cur_pfn, 2'h0}; // RULE20
      endcase
      next_pa = ({pa_pfn, 10'h000} & ~low_bits) | (i_lk_va & low_bits); // RULE1
      // Exceptions: miss first, then invalid, then modified
      lookup      = i_lk_valid & i_lk_mapped;
      next_refill = lookup & ~i_lk_hit & ~i_exception_level_flag; // RULE2
      next_nested = lookup & ~i_lk_hit & i_exception_level_flag;
      next_invalid = lookup & i_lk_hit & (~cur_present // RULE5
                   | (cur_lblk & (i_lk_ref == tpg_ref_load) & ~(~cur_fblk & i_lk_pc_rel_load))
                   | (cur_fblk & (i_lk_ref == tpg_ref_fetch)));
      next_modified = lookup & i_lk_hit & ~next_invalid & ~cur_permit
                    & (i_lk_ref == tpg_ref_store); // RULE6
      any_exc = next_refill | next_nested | next_invalid | next_modified;
   end

   // Register read multiplexer
   always_comb begin
      next_rdata = 32'h0000_0000;
      unique case (i_reg_sel)
         SEL_PAGE_SPAN:  next_rdata[SPAN_LO +: SPAN_W] = span & ~grain_wide; // RULE9 RULE8 RULE11
         SEL_GRAIN: begin
            next_rdata = GRAIN_RSV_ONES; // RULE21
            next_rdata[GRAIN_LB_POS] = load_block_enable;
            next_rdata[GRAIN_FB_POS] = fetch_block_enable;
            next_rdata[GRAIN_MASK_LO +: GRAIN_W] = grain; // RULE22
         end
         // Captured registers read back unchanged
         SEL_MATCH_HIGH: next_rdata = tlb_match_high;
         SEL_FRAME_EVEN: next_rdata = tlb_frame_even;
         SEL_FRAME_ODD:  next_rdata = tlb_frame_odd;
         SEL_FAULT_ADDR: next_rdata = faulting_address_reg;
         default:        next_rdata = 32'h0000_0000;
      endcase
   end

   // Page span: every size is implemented, inhibited low bits never store
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         span <= MASK_1K;
      end else if (i_ce) begin
         if (reg_write(i_reg_wr, i_reg_sel, SEL_PAGE_SPAN)) begin
            span <= i_reg_wdata[SPAN_LO +: SPAN_W] & ~grain_wide; // RULE7 RULE8 RULE12
         end else if (reg_write(i_reg_wr, i_reg_sel, SEL_GRAIN)) begin
            // Drop span bits that the new grain inhibits
            span <= span & ~widen(i_reg_wdata[GRAIN_MASK_LO +: GRAIN_W]); // RULE14
         end
      end
   end

   // Granularity control register
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         grain              <= GRAIN_MASK_RESET; // RULE18
         load_block_enable  <= 1'b0; // RULE16
         fetch_block_enable <= 1'b0; // RULE17
      end else if (i_ce && reg_write(i_reg_wr, i_reg_sel, SEL_GRAIN)) begin
         // Both mask bits are implemented, so every written code is kept
         grain              <= i_reg_wdata[GRAIN_MASK_LO +: GRAIN_W];
         load_block_enable  <= i_reg_wdata[GRAIN_LB_POS]; // RULE16
         fetch_block_enable <= i_reg_wdata[GRAIN_FB_POS]; // RULE17
      end
   end

   // Match-high: exception capture wins over a software write
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         tlb_match_high <= 32'h0000_0000;
      end else if (i_ce) begin
         if (any_exc) begin
            tlb_match_high <= {i_lk_va[31:MH_HI_LO],
                               i_lk_va[MH_HI_LO-1:MH_VPN_LO] & ~grain,
                               3'h0, i_lk_space_tag}; // RULE3
         end else if (reg_write(i_reg_wr, i_reg_sel, SEL_MATCH_HIGH)) begin
            // Reserved bits and grain-inhibited bits never store
            tlb_match_high <= i_reg_wdata & MH_WR_MASK
                            & ~(32'(grain) << MH_VPN_LO); // RULE19 RULE20
         end
      end
   end

   // Faulting address captured on every TLB exception
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         faulting_address_reg <= 32'h0000_0000;
      end else if (i_ce && any_exc) begin
         faulting_address_reg <= i_lk_va; // RULE4
      end
   end

   // Even frame register: block bits only store while enabled; exceptions leave it
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         tlb_frame_even <= 32'h0000_0000;
      end else if (i_ce && reg_write(i_reg_wr, i_reg_sel, SEL_FRAME_EVEN)) begin
         tlb_frame_even <= i_reg_wdata;
         tlb_frame_even[FR_LB_POS] <= i_reg_wdata[FR_LB_POS] & load_block_enable; // RULE16
         tlb_frame_even[FR_FB_POS] <= i_reg_wdata[FR_FB_POS] & fetch_block_enable; // RULE17
      end
   end

   // Odd frame register, same rules as the even one
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         tlb_frame_odd <= 32'h0000_0000;
      end else if (i_ce && reg_write(i_reg_wr, i_reg_sel, SEL_FRAME_ODD)) begin
         tlb_frame_odd <= i_reg_wdata;
         tlb_frame_odd[FR_LB_POS] <= i_reg_wdata[FR_LB_POS] & load_block_enable; // RULE16
         tlb_frame_odd[FR_FB_POS] <= i_reg_wdata[FR_FB_POS] & fetch_block_enable; // RULE17
      end
   end

   // Registered read data
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_reg_rdata <= 32'h0000_0000;
      end else if (i_ce && i_reg_rd) begin
         o_reg_rdata <= next_rdata;
      end
   end

   // Registered translation result and exception pulses
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_xlat_valid      <= 1'b0;
         o_pa              <= '0;
         o_exc_refill      <= 1'b0;
         o_exc_nested_miss <= 1'b0;
         o_exc_invalid     <= 1'b0;
         o_exc_modified    <= 1'b0;
         o_eff_mask        <= MASK_1K;
         o_mask_undefined  <= 1'b0;
      end else if (i_ce) begin
         // Translation result
         o_xlat_valid      <= lookup & i_lk_hit & ~next_invalid & ~next_modified;
         o_pa              <= next_pa;
         // Exception pulses stand for one cycle
         o_exc_refill      <= next_refill; // RULE2
         o_exc_nested_miss <= next_nested;
         o_exc_invalid     <= next_invalid; // RULE5
         o_exc_modified    <= next_modified; // RULE6
         // Mask used by this lookup
         o_eff_mask        <= next_eff_mask; // RULE23
         o_mask_undefined  <= lookup & i_lk_hit & next_undef;
      end
   end

   // Mirrors of register state for the TLB write path
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_wr_mask    <= MASK_1K;
         o_grain_mask <= GRAIN_MASK_RESET;
         o_match_high <= 32'h0000_0000;
         o_frame_even <= 32'h0000_0000;
         o_frame_odd  <= 32'h0000_0000;
      end else if (i_ce) begin
         // Inhibited span bits still count as excluded for TLB writes
         o_wr_mask    <= span | grain_wide; // RULE8
         o_grain_mask <= grain;
         o_match_high <= tlb_match_high;
         o_frame_even <= tlb_frame_even;
         o_frame_odd  <= tlb_frame_odd;
      end
   end

endmodule // tpg_page_grain

//--- core/tpg_pkg.sv
// Constants, field layouts and types for the page granularity logic
//Contract
//RULE1: Even/odd frame bit follows page size
//RULE2: No match with level flag clear: refill
//RULE3: Match-high loads failing address and tag
//RULE4: Faulting address captured; frame registers untouched
//RULE5: Matching entry not present: invalid exception
//RULE6: Store to non-writable valid page: modified
//RULE7: Size select field in span bits 24:11
//RULE8: Grain-inhibited span bits read zero, match ignored
//RULE9: Span bits 31:25 and 10:0 read zero
//RULE10: Size select encodings from 1K to 16M
//RULE11: Unimplemented size bits read back zero
//RULE12: 4K always; contiguous sizes down to grain
//RULE13: Software writes only listed span encodings
//RULE14: Span value may change after grain write
//RULE15: Software flushes TLB before grain changes
//RULE16: Bit 31 enables load block bit
//RULE17: Bit 30 enables fetch block bit
//RULE18: Two-bit grain mask at 12:11, reset 11
//RULE19: Grain 01: bit 12 used, bit 11 zero
//RULE20: Grain 11: bits 12:11 zero, 4K baseline
//RULE21: Grain bits 10:8 read as ones
//RULE22: Unimplemented grain bits read and act as 1
//RULE23: Effective mask formed in the lookup cycle
package tpg_pkg;
   localparam int PHYS_ADDR_WIDTH = 32;
   localparam int PFN_W           = PHYS_ADDR_WIDTH - 12;
   localparam int PA_PFN_W        = PHYS_ADDR_WIDTH - 10;
   localparam int SPAN_W          = 14;
   localparam int SPAN_LO         = 11;
   localparam int GRAIN_W         = 2;
   localparam int TAG_W           = 8;
   localparam int EO_W            = 5;
   // Register selects on the move-to / move-from port
   localparam logic [2:0] SEL_PAGE_SPAN   = 3'h0;
   localparam logic [2:0] SEL_GRAIN       = 3'h1;
   localparam logic [2:0] SEL_MATCH_HIGH  = 3'h2;
   localparam logic [2:0] SEL_FRAME_EVEN  = 3'h3;
   localparam logic [2:0] SEL_FRAME_ODD   = 3'h4;
   localparam logic [2:0] SEL_FAULT_ADDR  = 3'h5;
   // Granularity control layout
   localparam int GRAIN_LB_POS            = 31;
   localparam int GRAIN_FB_POS            = 30;
   localparam int GRAIN_MASK_LO           = 11;
   localparam logic [GRAIN_W-1:0] GRAIN_MASK_RESET = 2'h3;
   localparam logic [31:0] GRAIN_RSV_ONES = 32'h0000_0700;
   // Match-high layout
   localparam int MH_VPN_LO               = 11;
   localparam int MH_HI_LO                = 13;
   localparam logic [31:0] MH_WR_MASK     = 32'hFFFF_F8FF;
   // Frame register layout
   localparam int FR_LB_POS               = 31;
   localparam int FR_FB_POS               = 30;
   localparam int FR_PFN_LO               = 6;
   // Size select encodings
   localparam logic [SPAN_W-1:0] MASK_1K   = 14'h0000;
   localparam logic [SPAN_W-1:0] MASK_2K   = 14'h0001;
   localparam logic [SPAN_W-1:0] MASK_4K   = 14'h0003;
   localparam logic [SPAN_W-1:0] MASK_16K  = 14'h000F;
   localparam logic [SPAN_W-1:0] MASK_64K  = 14'h003F;
   localparam logic [SPAN_W-1:0] MASK_256K = 14'h00FF;
   localparam logic [SPAN_W-1:0] MASK_1M   = 14'h03FF;
   localparam logic [SPAN_W-1:0] MASK_4M   = 14'h0FFF;
   localparam logic [SPAN_W-1:0] MASK_16M  = 14'h3FFF;
   // Even/odd select bit per size
   localparam logic [EO_W-1:0] EO_1K   = 5'h0A;
   localparam logic [EO_W-1:0] EO_2K   = 5'h0B;
   localparam logic [EO_W-1:0] EO_4K   = 5'h0C;
   localparam logic [EO_W-1:0] EO_16K  = 5'h0E;
   localparam logic [EO_W-1:0] EO_64K  = 5'h10;
   localparam logic [EO_W-1:0] EO_256K = 5'h12;
   localparam logic [EO_W-1:0] EO_1M   = 5'h14;
   localparam logic [EO_W-1:0] EO_4M   = 5'h16;
   localparam logic [EO_W-1:0] EO_16M  = 5'h18;
   typedef enum logic [1:0] {tpg_ref_load, tpg_ref_store, tpg_ref_fetch} tpg_ref_type;
endpackage : tpg_pkg
